// [shared/fco_pkg.sv]
// Constants and types for the fieldbus configuration object bank.
// Assumes a 10 MHz system clock and 16-bit object index, 8-bit subindex.
package fco_pkg;
    // Object indices and subindices
    localparam logic [15:0] IDX_BOOT_POS = 16'h205a;
    localparam logic [15:0] IDX_MODE_SEL = 16'h205b;
    localparam logic [15:0] IDX_READY_DLY = 16'h2084;
    localparam logic [15:0] IDX_AVAIL = 16'h2101;
    localparam logic [15:0] IDX_ENABLE = 16'h2102;
    localparam logic [15:0] IDX_STATUS = 16'h2103;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_DISABLE = 8'h01;
    localparam logic [7:0] SUB_ACTIVE = 8'h02;
    localparam logic [31:0] STATUS_ENTRIES = 32'h0000_0002;

    // Interface bits, low half
    localparam int USB_IFACE_BIT = 0;
    localparam int SERIAL_485_IFACE_BIT = 1;
    localparam int SERIAL_232_IFACE_BIT = 2;
    localparam int CAN_IFACE_BIT = 3;
    localparam int PLAIN_ETHERNET_IFACE_BIT = 4;
    localparam int REALTIME_ETHERNET_IFACE_BIT = 5;
    localparam int SPI_IFACE_BIT = 6;
    // Protocol bits, high half
    localparam int MODBUS_RTU_PROTOCOL_BIT = 16;
    localparam int MODBUS_TCP_PROTOCOL_BIT = 17;
    localparam int INDUSTRIAL_IP_PROTOCOL_BIT = 18;

    // Fixed masks of this variant and reset values
    localparam logic [31:0] AVAIL_MASK = 32'h0019_0009;
    localparam logic [31:0] DISABLE_MASK = 32'h0000_0008;
    localparam logic [31:0] BOOT_POS_RST = 32'h0000_0000;
    localparam logic [31:0] MODE_SEL_RST = 32'h0000_0000;
    localparam logic [31:0] READY_DLY_RST = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RST = 32'h0019_0009;
    localparam logic [31:0] MODE_CW_CCW = 32'h0000_0001;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_IN_NS = 1000000;
    localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;

    // Object selected by an index/subindex pair
    typedef enum {
        SEL_NONE,
        SEL_BOOT,
        SEL_MODE,
        SEL_DELAY,
        SEL_AVAIL,
        SEL_ENABLE,
        SEL_ST_COUNT,
        SEL_ST_DISABLE,
        SEL_ST_ACTIVE
    } fco_sel_t;
endpackage

// [hw/fco_ms_timer.sv]
// Power-on readiness timer counting whole milliseconds.
// Assumes delay_ms_in comes from logic on the same clock.
`timescale 1ns/100ps
module fco_ms_timer #(
    parameter int CYC_PER_MS = fco_pkg::CYC_PER_MS
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [31:0] delay_ms_in,
    output logic ready_out
);
    typedef struct packed {
        logic [31:0] presc;
        logic [31:0] ms;
        logic ready;
    } fco_tmr_t;

    localparam logic [31:0] PRESC_LAST = 32'(CYC_PER_MS - 1);

    fco_tmr_t s_q, s_d;

    // Count milliseconds until the programmed delay has passed; once
    // ready stays ready, so a later larger delay cannot drop readiness
    always_comb begin
        s_d = s_q;
        if (!s_q.ready) begin
            if (s_q.ms >= delay_ms_in) begin
                s_d.ready = 1'b1;
            end else if (s_q.presc == PRESC_LAST) begin
                s_d.presc = 32'h0000_0000;
                s_d.ms = s_q.ms + 32'h0000_0001;
            end else begin
                s_d.presc = s_q.presc + 32'h0000_0001;
            end
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ready_out = s_q.ready;

    property p_ready_sticky;
        @(posedge clk_in) disable iff (!rst_b_in)
        s_q.ready |=> s_q.ready;
    endproperty
    a_ready_sticky: assert property (p_ready_sticky)
        else $error("Readiness dropped");

    property p_not_early;
        @(posedge clk_in) disable iff (!rst_b_in)
        $rose(s_q.ready) |-> $past(s_q.ms) >= $past(delay_ms_in);
    endproperty
    a_not_early: assert property (p_not_early)
        else $error("Ready before delay elapsed");
endmodule

// [hw/fco_config_objects.sv]
// Fieldbus configuration object bank: boot position, input mode,
// readiness delay, fieldbus availability, control and status.
// Assumes ENC_POS_IN is already in user units and on CLK_IN's domain,
// and that object accesses arrive as single-cycle strobes.
//
// What this block does
// - Capture encoder position at power-up, read-only
// - Mode zero pulse-direction, one clockwise/counter-clockwise
// - Signal readiness one cycle after reset release; a programmed delay has no effect
// - Low half interfaces, high half protocols
// - Interface bit positions zero through six
// - Protocol bit positions sixteen through eighteen
// - Availability mask is fixed and read-only
// - Control word enables fieldbuses, defaults to availability
// - Only switchable fieldbuses can be disabled
// - Active fieldbuses reported in read-only status
`timescale 1ns/100ps
module fco_config_objects #(
    parameter int CYC_PER_MS = fco_pkg::CYC_PER_MS
) (
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire logic [31:0] ENC_POS_IN,
    input wire logic [15:0] OD_INDEX_IN,
    input wire logic [7:0] OD_SUBINDEX_IN,
    input wire logic OD_WR_IN,
    input wire logic OD_RD_IN,
    input wire logic [31:0] OD_WDATA_IN,
    output logic [31:0] OD_RDATA_OUT,
    output logic OD_ACK_OUT,
    output logic OD_ERR_OUT,
    output logic CW_CCW_MODE_OUT,
    output logic READY_OUT,
    output logic [31:0] FB_ENABLE_OUT,
    output logic [31:0] FB_ACTIVE_OUT
);
    typedef struct packed {
        logic [31:0] boot_pos;
        logic booted;
        logic [31:0] mode_sel;
        logic [31:0] ready_dly;
        logic [31:0] enable;
        logic [31:0] active;
        logic cw_ccw;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } fco_state_t;

    fco_state_t s_q, s_d;
    fco_pkg::fco_sel_t sel;

    // Named positions; availability, control and status share one layout,
    // so a bit means the same fieldbus in each of these words
    localparam logic [31:0] IFACE_BITS =
        (32'h0000_0001 << fco_pkg::USB_IFACE_BIT) |
        (32'h0000_0001 << fco_pkg::SERIAL_485_IFACE_BIT) |
        (32'h0000_0001 << fco_pkg::SERIAL_232_IFACE_BIT) |
        (32'h0000_0001 << fco_pkg::CAN_IFACE_BIT) |
        (32'h0000_0001 << fco_pkg::PLAIN_ETHERNET_IFACE_BIT) |
        (32'h0000_0001 << fco_pkg::REALTIME_ETHERNET_IFACE_BIT) |
        (32'h0000_0001 << fco_pkg::SPI_IFACE_BIT);
    localparam logic [31:0] PROTO_BITS =
        (32'h0000_0001 << fco_pkg::MODBUS_RTU_PROTOCOL_BIT) |
        (32'h0000_0001 << fco_pkg::MODBUS_TCP_PROTOCOL_BIT) |
        (32'h0000_0001 << fco_pkg::INDUSTRIAL_IP_PROTOCOL_BIT);

    // Map an index/subindex pair onto an object
    function automatic fco_pkg::fco_sel_t decode(
        input logic [15:0] idx,
        input logic [7:0] sub
    );
        fco_pkg::fco_sel_t r;
        r = fco_pkg::SEL_NONE;
        if (idx == fco_pkg::IDX_STATUS) begin
            case (sub)
                fco_pkg::SUB_COUNT: r = fco_pkg::SEL_ST_COUNT;
                fco_pkg::SUB_DISABLE: r = fco_pkg::SEL_ST_DISABLE;
                fco_pkg::SUB_ACTIVE: r = fco_pkg::SEL_ST_ACTIVE;
                default: r = fco_pkg::SEL_NONE;
            endcase
        end else if (sub == fco_pkg::SUB_COUNT) begin
            case (idx)
                fco_pkg::IDX_BOOT_POS: r = fco_pkg::SEL_BOOT;
                fco_pkg::IDX_MODE_SEL: r = fco_pkg::SEL_MODE;
                fco_pkg::IDX_READY_DLY: r = fco_pkg::SEL_DELAY;
                fco_pkg::IDX_AVAIL: r = fco_pkg::SEL_AVAIL;
                fco_pkg::IDX_ENABLE: r = fco_pkg::SEL_ENABLE;
                default: r = fco_pkg::SEL_NONE;
            endcase
        end
        return r;
    endfunction

    assign sel = decode(OD_INDEX_IN, OD_SUBINDEX_IN);

    // Object accesses, boot capture and status derivation
    always_comb begin
        s_d = s_q;
        s_d.ack = OD_WR_IN | OD_RD_IN;
        s_d.err = 1'b0;
        // Position is caught in the first cycle after reset release
        if (!s_q.booted) begin
            s_d.boot_pos = ENC_POS_IN;
            s_d.booted = 1'b1;
        end
        if (OD_WR_IN) begin
            case (sel)
                fco_pkg::SEL_MODE: s_d.mode_sel = OD_WDATA_IN;
                fco_pkg::SEL_DELAY: s_d.ready_dly = OD_WDATA_IN;
                fco_pkg::SEL_ENABLE:
                    s_d.enable = OD_WDATA_IN & fco_pkg::AVAIL_MASK;
                default: s_d.err = 1'b1;
            endcase
        end else if (OD_RD_IN) begin
            case (sel)
                fco_pkg::SEL_BOOT: s_d.rdata = s_q.boot_pos;
                fco_pkg::SEL_MODE: s_d.rdata = s_q.mode_sel;
                fco_pkg::SEL_DELAY: s_d.rdata = s_q.ready_dly;
                fco_pkg::SEL_AVAIL: s_d.rdata = fco_pkg::AVAIL_MASK;
                fco_pkg::SEL_ENABLE: s_d.rdata = s_q.enable;
                fco_pkg::SEL_ST_COUNT: s_d.rdata = fco_pkg::STATUS_ENTRIES;
                fco_pkg::SEL_ST_DISABLE: s_d.rdata = fco_pkg::DISABLE_MASK;
                fco_pkg::SEL_ST_ACTIVE: s_d.rdata = s_q.active;
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.err = 1'b1;
                end
            endcase
        end
        // A cleared bit only stops a fieldbus that may be switched off
        s_d.active = fco_pkg::AVAIL_MASK &
            (s_q.enable | ~fco_pkg::DISABLE_MASK);
        s_d.cw_ccw = (s_q.mode_sel == fco_pkg::MODE_CW_CCW);
    end

    // State register; enable starts at the availability value
    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            s_q <= '0;
            s_q.boot_pos <= fco_pkg::BOOT_POS_RST;
            s_q.mode_sel <= fco_pkg::MODE_SEL_RST;
            s_q.ready_dly <= fco_pkg::READY_DLY_RST;
            s_q.enable <= fco_pkg::ENABLE_RST;
            s_q.active <= fco_pkg::AVAIL_MASK;
        end else begin
            s_q <= s_d;
        end
    end

    // Readiness delay counts from power-up with the live delay value
    fco_ms_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) fco_ms_timer_inst (
        .clk_in(CLK_IN),
        .rst_b_in(RST_B_IN),
        .delay_ms_in(s_q.ready_dly),
        .ready_out(READY_OUT)
    );

    assign OD_RDATA_OUT = s_q.rdata;
    assign OD_ACK_OUT = s_q.ack;
    assign OD_ERR_OUT = s_q.err;
    assign CW_CCW_MODE_OUT = s_q.cw_ccw;
    assign FB_ENABLE_OUT = s_q.enable;
    assign FB_ACTIVE_OUT = s_q.active;

    property p_boot_stable;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        s_q.booted |=> $stable(s_q.boot_pos);
    endproperty
    a_boot_stable: assert property (p_boot_stable)
        else $error("Boot position changed after capture");

    property p_boot_ro;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        OD_WR_IN && sel == fco_pkg::SEL_BOOT |=> OD_ERR_OUT && OD_ACK_OUT;
    endproperty
    a_boot_ro: assert property (p_boot_ro)
        else $error("Write to boot position not refused");

    property p_mode;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        OD_WR_IN && sel == fco_pkg::SEL_MODE
            |=> ##1 CW_CCW_MODE_OUT == ($past(OD_WDATA_IN, 2) ==
                fco_pkg::MODE_CW_CCW);
    endproperty
    a_mode: assert property (p_mode)
        else $error("Mode output does not follow selector");

    property p_avail_read;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        OD_RD_IN && !OD_WR_IN && sel == fco_pkg::SEL_AVAIL
            |=> OD_RDATA_OUT == 32'h0019_0009 && !OD_ERR_OUT;
    endproperty
    a_avail_read: assert property (p_avail_read)
        else $error("Availability read wrong");

    property p_enable_write;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        OD_WR_IN && sel == fco_pkg::SEL_ENABLE
            |=> FB_ENABLE_OUT == ($past(OD_WDATA_IN) & 32'h0019_0009);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("Control write not masked to available bits");

    property p_active;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        OD_WR_IN && sel == fco_pkg::SEL_ENABLE && OD_WDATA_IN == '0
            ##1 !OD_WR_IN |=> FB_ACTIVE_OUT == 32'h0019_0001;
    endproperty
    a_active: assert property (p_active)
        else $error("Active status wrong after disabling all");

    property p_ack;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        $past(RST_B_IN) |-> OD_ACK_OUT == $past(OD_WR_IN || OD_RD_IN);
    endproperty
    a_ack: assert property (p_ack)
        else $error("Acknowledge timing wrong");

    property p_active_subset;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        OD_RD_IN && !OD_WR_IN && sel == fco_pkg::SEL_ST_ACTIVE
            |=> (OD_RDATA_OUT & ~32'h0019_0009) == '0 &&
                (OD_RDATA_OUT | 32'h0000_0008) == 32'h0019_0009;
    endproperty
    a_active_subset: assert property (p_active_subset)
        else $error("Active status outside available set");

    // Named positions must show USB and CAN fitted and Modbus RTU available
    property p_named_bits;
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        OD_RD_IN && !OD_WR_IN && sel == fco_pkg::SEL_AVAIL
            |=> (OD_RDATA_OUT & IFACE_BITS) == 32'h0000_0009 &&
                (OD_RDATA_OUT & PROTO_BITS) == 32'h0001_0000;
    endproperty
    a_named_bits: assert property (p_named_bits)
        else $error("Named fieldbus positions misplaced");
endmodule

// [bench/fco_config_objects_tb.sv]
// Self-checking bench for the fieldbus configuration object bank.
// Assumes the one-cycle strobe/ack object access protocol of the block.
`timescale 1ns/100ps
module fco_config_objects_tb;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [31:0] enc_pos = 32'h0000_0000;
    logic [15:0] od_index = 16'h0000;
    logic [7:0] od_sub = 8'h00;
    logic od_wr = 1'b0;
    logic od_rd = 1'b0;
    logic [31:0] od_wdata = 32'h0000_0000;
    logic [31:0] od_rdata, fb_enable, fb_active, rd, ctl, exp_act;
    logic od_ack, od_err, cw_ccw, ready;
    int n_errors = 0;
    int n_tests = 0;

    // Short millisecond so the readiness timer runs in a few cycles
    fco_config_objects #(.CYC_PER_MS(4)) fco_config_objects_inst (
        .CLK_IN(clk_in),
        .RST_B_IN(rst_b_in),
        .ENC_POS_IN(enc_pos),
        .OD_INDEX_IN(od_index),
        .OD_SUBINDEX_IN(od_sub),
        .OD_WR_IN(od_wr),
        .OD_RD_IN(od_rd),
        .OD_WDATA_IN(od_wdata),
        .OD_RDATA_OUT(od_rdata),
        .OD_ACK_OUT(od_ack),
        .OD_ERR_OUT(od_err),
        .CW_CCW_MODE_OUT(cw_ccw),
        .READY_OUT(ready),
        .FB_ENABLE_OUT(fb_enable),
        .FB_ACTIVE_OUT(fb_active)
    );

    // 100 ns period
    always #50 clk_in = ~clk_in;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic finish_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One strobe cycle; the answer is fixed at one cycle later
    task automatic od_xfer(input logic wr, input logic [15:0] idx,
        input logic [7:0] sub, input logic [31:0] wd, input logic exp_err);
        @(posedge clk_in);
        #1;
        od_wr = wr;
        od_rd = !wr;
        od_index = idx;
        od_sub = sub;
        od_wdata = wd;
        @(posedge clk_in);
        #1;
        od_wr = 1'b0;
        od_rd = 1'b0;
        rd = od_rdata;
        check({31'h0, od_ack}, 32'h1);
        check({31'h0, od_err}, {31'h0, exp_err});
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] exp, input logic exp_err);
        od_xfer(1'b0, idx, sub, 32'h0000_0000, exp_err);
        check(rd, exp);
    endtask

    // Reset for 20 cycles; position changes right after capture edge.
    // A zero delay gives readiness at the first edge after release.
    task automatic do_reset(input logic [31:0] pos);
        @(posedge clk_in);
        #1;
        rst_b_in = 1'b0;
        enc_pos = pos;
        repeat (20) @(posedge clk_in);
        #1;
        check({31'h0, ready}, 32'h0);
        rst_b_in = 1'b1;
        @(posedge clk_in);
        #1;
        enc_pos = ~pos;
        check({31'h0, ready}, 32'h1);
        check(fb_enable, fco_pkg::ENABLE_RST);
        check(fb_active, fco_pkg::AVAIL_MASK);
        check({31'h0, cw_ccw}, 32'h0);
        @(posedge clk_in);
        #1;
        check({31'h0, ready}, 32'h1);
    endtask

    // Hang guard: a stuck run counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        finish_test();
    end

    initial begin
        do_reset(32'hfedc_ba98);
        rd_chk(fco_pkg::IDX_BOOT_POS, 8'h00, 32'hfedc_ba98, 1'b0);
        od_xfer(1'b1, fco_pkg::IDX_BOOT_POS, 8'h00, 32'h1, 1'b1);
        rd_chk(fco_pkg::IDX_BOOT_POS, 8'h00, 32'hfedc_ba98, 1'b0);
        rd_chk(fco_pkg::IDX_MODE_SEL, 8'h00, 32'h0, 1'b0);
        rd_chk(fco_pkg::IDX_READY_DLY, 8'h00, 32'h0, 1'b0);
        rd_chk(fco_pkg::IDX_AVAIL, 8'h00, 32'h0019_0009, 1'b0);
        rd_chk(fco_pkg::IDX_ENABLE, 8'h00, 32'h0019_0009, 1'b0);
        rd_chk(fco_pkg::IDX_STATUS, 8'h00, 32'h2, 1'b0);
        rd_chk(fco_pkg::IDX_STATUS, 8'h01, 32'h8, 1'b0);
        rd_chk(fco_pkg::IDX_STATUS, 8'h02, 32'h0019_0009, 1'b0);
        od_xfer(1'b1, fco_pkg::IDX_STATUS, 8'h02, 32'h0, 1'b1);
        od_xfer(1'b1, fco_pkg::IDX_AVAIL, 8'h00, 32'h0, 1'b1);
        rd_chk(fco_pkg::IDX_AVAIL, 8'h00, 32'h0019_0009, 1'b0);
        rd_chk(16'h1234, 8'h00, 32'h0, 1'b1);
        rd_chk(fco_pkg::IDX_AVAIL, 8'h01, 32'h0, 1'b1);
        // Mode selector: only exactly one picks rotation-pulse input
        for (int m = 0; m < 4; m++) begin
            ctl = (m == 3) ? 32'h0 : m[31:0] + 32'h1;
            od_xfer(1'b1, fco_pkg::IDX_MODE_SEL, 8'h00, ctl, 1'b0);
            @(posedge clk_in);
            #1;
            check({31'h0, cw_ccw}, {31'h0, ctl == 32'h1});
            rd_chk(fco_pkg::IDX_MODE_SEL, 8'h00, ctl, 1'b0);
        end
        // Delay is plain storage here; readiness stays sticky
        ctl = 32'hffff_ffff;
        od_xfer(1'b1, fco_pkg::IDX_READY_DLY, 8'h00, ctl, 1'b0);
        rd_chk(fco_pkg::IDX_READY_DLY, 8'h00, 32'hffff_ffff, 1'b0);
        check({31'h0, ready}, 32'h1);
        od_xfer(1'b1, fco_pkg::IDX_ENABLE, 8'h00, ctl, 1'b0);
        rd_chk(fco_pkg::IDX_ENABLE, 8'h00, 32'h0019_0009, 1'b0);
        // Walk one control bit at a time over the whole word
        for (int i = 0; i < 32; i++) begin
            ctl = 32'h1 << i;
            od_xfer(1'b1, fco_pkg::IDX_ENABLE, 8'h00, ctl, 1'b0);
            check(fb_enable, ctl & 32'h0019_0009);
            @(posedge clk_in);
            #1;
            exp_act = 32'h0019_0009 & ((ctl & 32'h0019_0009) | ~32'h0000_0008);
            check(fb_active, exp_act);
            rd_chk(fco_pkg::IDX_STATUS, 8'h02, exp_act, 1'b0);
        end
        od_xfer(1'b1, fco_pkg::IDX_ENABLE, 8'h00, 32'h0, 1'b0);
        @(posedge clk_in);
        #1;
        check(fb_active, 32'h0019_0001);
        od_xfer(1'b1, fco_pkg::IDX_MODE_SEL, 8'h00, 32'h1, 1'b0);
        // Mid-run reset brings every writable object back to its default and recaptures position
        do_reset(32'h0000_0123);
        rd_chk(fco_pkg::IDX_BOOT_POS, 8'h00, 32'h0000_0123, 1'b0);
        rd_chk(fco_pkg::IDX_ENABLE, 8'h00, 32'h0019_0009, 1'b0);
        rd_chk(fco_pkg::IDX_MODE_SEL, 8'h00, 32'h0, 1'b0);
        rd_chk(fco_pkg::IDX_READY_DLY, 8'h00, 32'h0, 1'b0);
        finish_test();
    end
endmodule
